/* File: sim/lock_link_asserts.sv */
/*
 * Concurrent checks on the partition lock link between both ends.
 * Assumes one clock, ref_clk, and rst_n low while in reset.
 */
module lock_link_asserts
    import lock_pkg::*;
#(
    parameter int PW         = 4,
    parameter int HOLD_LIMIT = 8
) (
    // Clock and reset.
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // Packet offered by the parties.
    input  wire logic          pkt_valid,
    input  wire logic [PW-1:0] pkt_src,
    input  wire logic [PW-1:0] pkt_dst,
    input  tlp_kind_e          pkt_kind,
    input  wire logic          pkt_vc0,
    input  wire logic          pkt_ack,
    // Side-band register access.
    input  wire logic          sb_req,
    input  wire logic          sb_ack,
    // Lock status.
    input  wire logic          bus_locked,
    input  wire logic          dn_locked,
    input  wire logic [PW-1:0] lock_port
);
    localparam int HOLD_MAX = HOLD_LIMIT + 1;

    // A VC0 packet aimed at a locked port from a port the lock shuts out.
    wire blocked = pkt_vc0 && pkt_kind != K_OWNMSG
        && ((dn_locked && pkt_dst == lock_port && pkt_src != 0)
        || (bus_locked && pkt_dst == 0 && pkt_src != lock_port));

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // The acknowledge is a single-cycle pulse.
    a_ack_one_pulse: assert property (pkt_ack |=> !pkt_ack)
        else $error("pkt_ack held longer than one cycle");
    a_read_locks_port: assert property (
        pkt_ack && pkt_kind == K_MRDLK && pkt_src == 0 && pkt_dst != 0
        && !$past(dn_locked) |-> dn_locked && lock_port == pkt_dst)
        else $error("locked read did not lock its port");
    a_cpl_bus_locks: assert property (
        pkt_ack && pkt_kind == K_CPLDLK && $past(dn_locked) && pkt_dst == 0
        && pkt_src == $past(lock_port) |-> bus_locked && dn_locked)
        else $error("locked completion did not bus-lock");
    a_locked_state_kept: assert property (
        pkt_ack && $past(bus_locked) && pkt_kind inside {K_MRDLK, K_CPLLK,
        K_CPLDLK, K_MWR} |-> bus_locked && $stable(lock_port))
        else $error("lock state changed during bus lock");
    a_unlock_frees_all: assert property (
        pkt_ack && pkt_kind == K_UNLOCK && pkt_src == 0 && $past(dn_locked)
        |-> !dn_locked && !bus_locked)
        else $error("unlock left the partition locked");
    a_unlock_ignored: assert property (
        pkt_ack && pkt_kind == K_UNLOCK && !$past(dn_locked)
        |-> !dn_locked && !bus_locked && $stable(lock_port))
        else $error("unlock changed an unlocked partition");
    a_held_waits: assert property (
        $rose(pkt_valid) && blocked |-> ##1 !pkt_ack [*4])
        else $error("blocked packet taken at once");
    a_held_bounded: assert property (
        $rose(pkt_valid) && blocked |-> ##[1:HOLD_MAX] pkt_ack)
        else $error("blocked packet held past its timeout");
    a_other_vc_free: assert property (
        $rose(pkt_valid) && !pkt_vc0 && pkt_kind == K_MWR |-> ##1 pkt_ack)
        else $error("non-VC0 write was delayed");
    a_other_port_free: assert property (
        $rose(pkt_valid) && pkt_kind == K_MWR && dn_locked
        && pkt_dst != lock_port && pkt_dst != 0 |-> ##1 pkt_ack)
        else $error("write to an unlocked port was delayed");
    a_own_msg_free: assert property (
        $rose(pkt_valid) && pkt_kind == K_OWNMSG |-> ##1 pkt_ack)
        else $error("inserted message was delayed");
    a_sideband_answer: assert property (
        $rose(sb_req) |-> ##1 sb_ack)
        else $error("side-band access not answered");
endmodule

/* File: sim/switch_partition_bus_lock_bench.sv */
/*
 * Self-checking bench joining the switch end and the party end.
 * Assumes a 25 MHz ref_clk and a shortened hold timeout of 8 cycles.
 */
module switch_partition_bus_lock_bench
    import lock_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int HOLD = 8;
    localparam int CEIL = 4000;

    typedef struct {
        logic [3:0] s;
        logic [3:0] d;
        tlp_kind_e  k;
        logic       v;
        logic [4:0] e;
    } row_s;

    logic        ref_clk, rst_n, req_valid, req_vc0, sb_go;
    logic [3:0]  req_src, req_dst, fwd_src_q, fwd_dst_q, lock_port_q;
    tlp_kind_e   req_kind, fwd_kind_q;
    logic [15:0] posted_pend;
    logic        fwd_valid_q, drop_q, held_q, bus_locked_q, dn_locked_q;
    logic        req_done_q, req_refused_q, sb_done_q, sb_access_q;
    logic        fwd_seen, drop_seen, refused, held_seen, sb_seen;
    int          mismatches, samples_checked, cycles, cyc;
    row_s        r;

    // Flags per row: refused, forwarded, dropped, bus locked, port locked.
    row_s rows [19] = '{
        '{4'h0, 4'h2, K_MWR,    1'b1, 5'h08},
        '{4'h0, 4'h3, K_UNLOCK, 1'b1, 5'h00},
        '{4'h0, 4'h3, K_MRDLK,  1'b1, 5'h09},
        '{4'h5, 4'h3, K_MWR,    1'b1, 5'h05},
        '{4'h5, 4'h3, K_MWR,    1'b0, 5'h09},
        '{4'h3, 4'h0, K_CPLDLK, 1'b1, 5'h0B},
        '{4'h4, 4'h6, K_MWR,    1'b1, 5'h0B},
        '{4'h5, 4'h0, K_MWR,    1'b1, 5'h07},
        '{4'h4, 4'h0, K_OWNMSG, 1'b1, 5'h0B},
        '{4'h0, 4'h3, K_MRDLK,  1'b1, 5'h0B},
        '{4'h3, 4'h0, K_CPLLK,  1'b1, 5'h0B},
        '{4'h3, 4'h0, K_CPLDLK, 1'b1, 5'h0B},
        '{4'h0, 4'h3, K_MWR,    1'b1, 5'h0B},
        '{4'h0, 4'h3, K_CFG,    1'b1, 5'h13},
        '{4'h0, 4'h5, K_MRDLK,  1'b1, 5'h13},
        '{4'h3, 4'h0, K_MRD,    1'b1, 5'h13},
        '{4'h0, 4'h3, K_MRD,    1'b1, 5'h13},
        '{4'h0, 4'h3, K_UNLOCK, 1'b1, 5'h08},
        '{4'h5, 4'h3, K_MWR,    1'b1, 5'h08}
    };

    lock_link_if link ();

    lock_switch_end #(.HOLD_LIMIT(HOLD)) u_lock_switch_end (
        .ref_clk, .rst_n, .link(link), .posted_pend, .fwd_valid_q,
        .fwd_src_q, .fwd_dst_q, .fwd_kind_q, .drop_q, .held_q,
        .sb_access_q, .bus_locked_q, .dn_locked_q, .lock_port_q);

    lock_party_end u_lock_party_end (
        .ref_clk, .rst_n, .link(link), .req_valid, .req_src, .req_dst,
        .req_kind, .req_vc0, .sb_go, .req_done_q, .req_refused_q,
        .sb_done_q);

    lock_link_asserts #(.PW(4), .HOLD_LIMIT(HOLD)) u_lock_link_asserts (
        .ref_clk, .rst_n, .pkt_valid(link.pkt_valid),
        .pkt_src(link.pkt_src), .pkt_dst(link.pkt_dst),
        .pkt_kind(link.pkt_kind), .pkt_vc0(link.pkt_vc0),
        .pkt_ack(link.pkt_ack), .sb_req(link.sb_req), .sb_ack(link.sb_ack),
        .bus_locked(link.bus_locked), .dn_locked(link.dn_locked),
        .lock_port(link.lock_port));

    // The clock toggles every half period of 20 ns.
    always #20 ref_clk = ~ref_clk;

    // Pulses are latched for the running transfer; a hang ends the run.
    always @(posedge ref_clk) begin
        cycles++;
        if (fwd_valid_q === 1'b1) fwd_seen = 1'b1;
        if (drop_q === 1'b1) drop_seen = 1'b1;
        if (held_q === 1'b1) held_seen = 1'b1;
        if (sb_access_q === 1'b1) sb_seen = 1'b1;
        if (cycles == CEIL) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [4:0] seen,
                         input logic [4:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Offers one request and holds it until it is done or refused, or for at most 40 cycles.
    task automatic send(input logic [3:0] s, d, input tlp_kind_e k,
                        input logic v);
        fwd_seen = 1'b0;
        drop_seen = 1'b0;
        held_seen = 1'b0;
        cyc = 0;
        req_src <= s;
        req_dst <= d;
        req_kind <= k;
        req_vc0 <= v;
        req_valid <= 1'b1;
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (req_done_q !== 1'b1 && req_refused_q !== 1'b1
                   && cyc < 40);
        refused = req_refused_q;
        req_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    // Sends with posted traffic pending for six cycles; it must wait.
    task automatic order(input logic [3:0] s, d, input tlp_kind_e k,
                         input int pb);
        posted_pend <= 16'h0001 << pb;
        fork
            send(s, d, k, 1'b1);
            begin
                repeat (6) @(posedge ref_clk);
                posted_pend <= 16'h0000;
            end
        join
        check("order_wait", {4'h0, cyc > 6},
              5'h01);
    endtask

    task automatic end_sim();
        $display("samples_checked %0d mismatches %0d", samples_checked,
                 mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence: reset, the table of rows, ordering, reset mid-lock.
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_src = 4'h0;
        req_dst = 4'h0;
        req_kind = K_MWR;
        req_vc0 = 1'b0;
        sb_go = 1'b0;
        posted_pend = 16'h0000;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        fwd_seen = 1'b0;
        drop_seen = 1'b0;
        held_seen = 1'b0;
        sb_seen = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check("reset", {held_q, bus_locked_q, dn_locked_q, lock_port_q[1:0]},
              5'h00);
        foreach (rows[i]) begin
            r = rows[i];
            send(r.s, r.d, r.k, r.v);
            check("refused", {4'h0, refused},
                  {4'h0, r.e[4]});
            check("flags", {3'b000, fwd_seen, drop_seen},
                  {3'b000, r.e[3:2]});
            check("held", {4'h0, held_seen},
                  {4'h0, r.e[2]});
            check("state", {3'b000, bus_locked_q, dn_locked_q},
                  {3'b000, r.e[1:0]});
            if (r.e[3]) begin
                check("fwd_dst", {1'b0, fwd_dst_q}, {1'b0, r.d});
                check("fwd_src", {1'b0, fwd_src_q}, {1'b0, r.s});
                check("fwd_kind", {1'b0, fwd_kind_q}, {1'b0, r.k});
            end
        end
        order(4'h0, 4'h3, K_MRDLK, 3);
        order(4'h3, 4'h0, K_CPLDLK, 0);
        sb_go <= 1'b1;
        @(posedge ref_clk);
        sb_go <= 1'b0;
        cyc = 0;
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (sb_done_q !== 1'b1 && cyc < 10);
        check("sideband", {2'b00, sb_seen, sb_done_q, bus_locked_q},
              5'h07);
        order(4'h0, 4'h3, K_UNLOCK, 3);
        send(4'h0, 4'h5, K_MRDLK, 1'b1);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        check("mid_reset", {held_q, bus_locked_q, dn_locked_q,
              lock_port_q[1:0]}, 5'h00);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        send(4'h6, 4'h5, K_MWR, 1'b1);
        check("after_reset", {3'b000, fwd_seen, drop_seen}, 5'h02);
        end_sim();
    end
endmodule

/* File: src/hold_timer.sv */
/*
 * Counts how long a packet has been held back by a lock.
 * Assumes run stays high for as long as the same packet waits.
 */
module hold_timer #(
    parameter int LIMIT = 16,
    parameter int CW    = $clog2(LIMIT + 1)
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Control and result.
    input  wire logic run,
    output logic      expired
);
    logic [CW-1:0] cnt_q;
    wire           at_limit = (cnt_q == CW'(LIMIT));

    // Count while held, restart once the wait ends.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (!at_limit) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign expired = at_limit;
endmodule

/* File: src/lock_link_if.sv */
/*
 * Link between the switch partition and the parties around it.
 * Assumes both ends run on ref_clk; no clocking block is used.
 */
`include "lock_map.svh"

interface lock_link_if
    import lock_pkg::*;
#(
    parameter int NPORT = `LK_NPORT,
    parameter int PW    = $clog2(NPORT)
);
    // Packet offered by the parties.
    logic            pkt_valid;
    logic [PW-1:0]   pkt_src;
    logic [PW-1:0]   pkt_dst;
    tlp_kind_e       pkt_kind;
    logic            pkt_vc0;
    logic            pkt_ack;
    // Side-band register access.
    logic            sb_req;
    logic            sb_ack;
    // Lock status seen by the parties.
    logic            bus_locked;
    logic            dn_locked;
    logic [PW-1:0]   lock_port;

    // Switch partition end.
    modport switch_end (
        input  pkt_valid, pkt_src, pkt_dst, pkt_kind, pkt_vc0, sb_req,
        output pkt_ack, sb_ack, bus_locked, dn_locked, lock_port
    );

    // Root complex and endpoint end.
    modport party_end (
        output pkt_valid, pkt_src, pkt_dst, pkt_kind, pkt_vc0, sb_req,
        input  pkt_ack, sb_ack, bus_locked, dn_locked, lock_port
    );
endinterface

/* File: src/lock_map.svh */
/*
 * Constants of the partition bus-lock tracker: port numbering, timing
 * and reset values.
 * Assumes a single 25 MHz core clock and one partition per instance.
 */
`ifndef LOCK_MAP_SVH
`define LOCK_MAP_SVH

// Number of switch ports in the partition and the upstream port index.
`define LK_NPORT            16
`define LK_UP_PORT          0

// Core clock period in nanoseconds.
`define LK_CLK_PERIOD_NS    40

// Time a held packet waits before the switch discards it, in microseconds.
`define LK_HOLD_TIMEOUT_US  50000

// Hold time in core clock cycles, rounded down.
`define LK_HOLD_CYCLES \
    ((`LK_HOLD_TIMEOUT_US * 1000) / `LK_CLK_PERIOD_NS)

// Reset value of the lock state outputs.
`define LK_RST_LOCKED       1'b0

`endif

/* File: src/lock_party_end.sv */
/*
 * Root complex and legacy endpoint side of the partition lock link:
 * offers one packet at a time and refuses what may not be sent while
 * the partition is bus-locked.
 * Assumes the user side holds a request until done or refused.
 */
`include "lock_map.svh"

module lock_party_end
    import lock_pkg::*;
#(
    parameter int NPORT = `LK_NPORT,
    parameter int PW    = $clog2(NPORT)
) (
    // Clock and reset.
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // Link to the switch.
    lock_link_if.party_end     link,
    // User request.
    input  wire logic          req_valid,
    input  wire logic [PW-1:0] req_src,
    input  wire logic [PW-1:0] req_dst,
    input  tlp_kind_e          req_kind,
    input  wire logic          req_vc0,
    input  wire logic          sb_go,
    // User answers.
    output logic               req_done_q,
    output logic               req_refused_q,
    output logic               sb_done_q
);
    localparam logic [PW-1:0] UP = PW'(`LK_UP_PORT);

    party_state_e  st_q;
    logic          valid_q;
    logic [PW-1:0] src_q;
    logic [PW-1:0] dst_q;
    tlp_kind_e     kind_q;
    logic          vc0_q;
    logic          sb_req_q;

    // Checks against what a bus-locked partition may receive.
    wire host_in   = (req_src == UP);
    wire ep_in     = link.dn_locked && (req_src == link.lock_port);
    wire host_ok   = (req_kind == K_MWR) || (req_kind == K_MRDLK)
                     || (req_kind == K_UNLOCK);
    wire ep_ok     = (req_kind == K_CPLLK) || (req_kind == K_CPLDLK);
    wire to_locked = (req_dst == link.lock_port) || (req_kind == K_UNLOCK);
    wire bad_cfg   = (req_kind == K_CFG);
    wire bad_host  = host_in && (!host_ok || !to_locked);
    wire bad_ep    = ep_in && !ep_ok;
    wire refuse    = link.bus_locked && (bad_cfg || bad_host || bad_ep);
    // The user drops its request one cycle after an answer, so that
    // cycle is skipped; otherwise the same request would be sent twice.
    wire fresh     = req_valid && !req_done_q && !req_refused_q;

    // Offer a request and wait for the switch to take it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q          <= P_IDLE;
            valid_q       <= 1'b0;
            src_q         <= UP;
            dst_q         <= UP;
            kind_q        <= K_MWR;
            vc0_q         <= 1'b0;
            req_done_q    <= 1'b0;
            req_refused_q <= 1'b0;
        end else begin
            req_done_q    <= 1'b0;
            req_refused_q <= 1'b0;
            case (st_q)
                P_IDLE: begin
                    if (fresh && refuse) begin
                        req_refused_q <= 1'b1;
                    end else if (fresh) begin
                        st_q    <= P_WAIT;
                        valid_q <= 1'b1;
                        src_q   <= req_src;
                        dst_q   <= req_dst;
                        kind_q  <= req_kind;
                        vc0_q   <= req_vc0;
                    end
                end
                P_WAIT: begin
                    if (link.pkt_ack) begin
                        st_q       <= P_IDLE;
                        valid_q    <= 1'b0;
                        req_done_q <= 1'b1;
                    end
                end
                default: begin
                    st_q    <= P_IDLE;
                    valid_q <= 1'b0;
                end
            endcase
        end
    end

    // Side-band request held until answered.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_req_q  <= 1'b0;
            sb_done_q <= 1'b0;
        end else begin
            sb_done_q <= link.sb_ack;
            if (link.sb_ack) begin
                sb_req_q <= 1'b0;
            end else if (sb_go) begin
                sb_req_q <= 1'b1;
            end
        end
    end

    // Descriptor driven onto the link.
    assign link.pkt_valid = valid_q;
    assign link.pkt_src   = src_q;
    assign link.pkt_dst   = dst_q;
    assign link.pkt_kind  = kind_q;
    assign link.pkt_vc0   = vc0_q;
    assign link.sb_req    = sb_req_q;
endmodule

/* File: src/lock_pkg.sv */
/*
 * Types shared by both ends of the partition bus-lock link.
 * Assumes lock_map.svh supplies the numeric constants.
 */
package lock_pkg;

    // Kind of transaction carried by one packet descriptor.
    typedef enum logic [3:0] {
        K_MWR,
        K_MRD,
        K_MRDLK,
        K_CPL,
        K_CPLD,
        K_CPLLK,
        K_CPLDLK,
        K_CFG,
        K_UNLOCK,
        K_MSG,
        K_OWNMSG
    } tlp_kind_e;

    // Lock progress of the partition.
    typedef enum logic [1:0] {
        S_IDLE,
        S_DN_LOCKED,
        S_BUS_LOCKED
    } lock_state_e;

    // State of the traffic source at the far end.
    typedef enum logic [0:0] {
        P_IDLE,
        P_WAIT
    } party_state_e;

endpackage

/* File: src/lock_switch_end.sv */
/*
 * Bus-lock tracker of one switch partition: establishes, keeps and
 * releases a legacy lock, holds VC0 packets aimed at locked ports and
 * orders locked requests, completions and Unlock behind posted traffic.
 * Assumes the egress queues report pending posted requests per port on
 * posted_pend and that port `LK_UP_PORT is the upstream switch port.
 */
// Notes on behaviour
// - One lock at a time, upstream to downstream.
// - Locked read forwarded, then its port locked.
// - Only VC0 packets are held by locks.
// - Posted traffic leaves before the locked read.
// - Locked downstream port blocks nothing else.
// - Locked data completion forwarded, upstream then locked.
// - Posted traffic upstream leaves before locked data completion.
// - Bus-locked once completion returned, upstream locked.
// - Host sends no configuration access while locked.
// - Side-band register access keeps working while locked.
// - Further locked reads and completions keep state.
// - Host memory writes pass without changing state.
// - Locked ports still insert own messages.
// - Host sends only writes, locked reads, Unlock.
// - Endpoint returns only locked completions while locked.
// - Host sends nothing to unlocked downstream ports.
// - Unlock frees partition and goes to locked port.
// - Posted traffic queued at the locked port leaves before unlocking.
// - Unlock at an unlocked partition is ignored.
// - Held packets wait, or drop on timeout.
`include "lock_map.svh"

module lock_switch_end
    import lock_pkg::*;
#(
    parameter int NPORT      = `LK_NPORT,
    parameter int PW         = $clog2(NPORT),
    parameter int HOLD_LIMIT = `LK_HOLD_CYCLES
) (
    // Clock and reset.
    input  wire logic            ref_clk,
    input  wire logic            rst_n,
    // Link to the parties.
    lock_link_if.switch_end      link,
    // Egress queue status.
    input  wire logic [NPORT-1:0] posted_pend,
    // Forwarded packet.
    output logic                 fwd_valid_q,
    output logic [PW-1:0]        fwd_src_q,
    output logic [PW-1:0]        fwd_dst_q,
    output tlp_kind_e            fwd_kind_q,
    // Discarded packet and hold status.
    output logic                 drop_q,
    output logic                 held_q,
    // Side-band register access.
    output logic                 sb_access_q,
    // Lock status.
    output logic                 bus_locked_q,
    output logic                 dn_locked_q,
    output logic [PW-1:0]        lock_port_q
);
    localparam logic [PW-1:0] UP = PW'(`LK_UP_PORT);

    lock_state_e   state_q;
    lock_state_e   state_d;
    logic [PW-1:0] lock_port_d;
    logic          ack_q;
    logic          sb_ack_q;
    logic          expired;

    // True when the port number is the upstream switch port.
    function automatic logic is_up(input logic [PW-1:0] p);
        return p == UP;
    endfunction

    // Descriptor fields on the link.
    wire           pkt_new  = link.pkt_valid && !ack_q;
    wire [PW-1:0]  src      = link.pkt_src;
    wire [PW-1:0]  dst      = link.pkt_dst;
    wire tlp_kind_e kind    = link.pkt_kind;
    wire           from_up  = is_up(src);
    wire           to_up    = is_up(dst);
    wire           locked_a = (state_q != S_IDLE);
    wire           locked_b = (state_q == S_BUS_LOCKED);

    // Messages that a port inserts itself are never held.
    wire           own_msg  = (kind == K_OWNMSG);
    wire           lockable = link.pkt_vc0 && !own_msg;

    // Downstream lock holds VC0 traffic aimed at it from others.
    wire           dn_block = locked_a && (dst == lock_port_q)
                              && !from_up;
    // Upstream lock holds VC0 traffic aimed at it from others.
    wire           up_block = locked_b && to_up
                              && (src != lock_port_q);
    // Other destinations are never held by this lock.
    wire           blocked  = lockable
                              && (dn_block || up_block);

    // Locked read waits for posted writes queued at its egress.
    wire           rdlk_wait = (kind == K_MRDLK)
                               && posted_pend[dst];
    // Locked data completion waits for posted writes queued upstream.
    wire           cpl_wait  = (kind == K_CPLDLK) && locked_a
                               && (src == lock_port_q)
                               && posted_pend[UP];
    // Unlock waits for posted writes queued at the locked port's egress.
    wire           unl_wait  = (kind == K_UNLOCK) && locked_a
                               && posted_pend[lock_port_q];
    wire           order_wait = rdlk_wait || cpl_wait || unl_wait;

    // Unlock is taken from the upstream port at a locked partition.
    wire           unlock_ok = (kind == K_UNLOCK) && from_up && locked_a;
    // An Unlock with no lock to release is swallowed.
    wire           unlock_ign = (kind == K_UNLOCK) && !unlock_ok;

    // A held packet is taken either when freed or when it times out.
    wire           pass     = pkt_new && !blocked && !order_wait;
    wire           discard  = pkt_new && blocked && expired;
    wire           take     = pass || discard;
    wire           fwd_now  = pass && !unlock_ign;
    wire [PW-1:0]  fwd_dst  = unlock_ok ? lock_port_q : dst;

    // Hold timer runs only while a packet waits on a lock.
    hold_timer #(
        .LIMIT   (HOLD_LIMIT)
    ) u_hold (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .run     (pkt_new && blocked),
        .expired (expired)
    );

    // Lock progress; only packets actually forwarded move it.
    always_comb begin
        state_d     = state_q;
        lock_port_d = lock_port_q;
        if (pass) begin
            case (state_q)
                S_IDLE: begin
                    // A second lock cannot start while one is held.
                    if (kind == K_MRDLK && from_up && !to_up) begin
                        state_d     = S_DN_LOCKED;
                        lock_port_d = dst;
                    end
                end
                S_DN_LOCKED: begin
                    if (unlock_ok) begin
                        state_d = S_IDLE;
                    end else if (kind == K_CPLDLK
                                 && src == lock_port_q
                                 && to_up) begin
                        state_d = S_BUS_LOCKED;
                    end
                end
                S_BUS_LOCKED: begin
                    // Reads, writes and completions leave state alone.
                    if (unlock_ok) begin
                        state_d = S_IDLE;
                    end else begin
                        state_d = S_BUS_LOCKED;
                    end
                end
                default: begin
                    state_d = S_IDLE;
                end
            endcase
        end
    end

    // Lock state and its status outputs.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= S_IDLE;
            lock_port_q  <= UP;
            bus_locked_q <= `LK_RST_LOCKED;
            dn_locked_q  <= `LK_RST_LOCKED;
        end else begin
            state_q      <= state_d;
            lock_port_q  <= lock_port_d;
            bus_locked_q <= (state_d == S_BUS_LOCKED);
            dn_locked_q  <= (state_d != S_IDLE);
        end
    end

    // Packet acceptance, forwarding and discard reports.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q       <= 1'b0;
            fwd_valid_q <= 1'b0;
            fwd_src_q   <= UP;
            fwd_dst_q   <= UP;
            fwd_kind_q  <= K_MWR;
            drop_q      <= 1'b0;
            held_q      <= 1'b0;
        end else begin
            ack_q       <= take;
            fwd_valid_q <= fwd_now;
            drop_q      <= discard;
            held_q      <= pkt_new && blocked && !expired;
            if (fwd_now) begin
                fwd_src_q  <= src;
                fwd_dst_q  <= fwd_dst;
                fwd_kind_q <= kind;
            end
        end
    end

    // Side-band access is answered whatever the lock state.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_ack_q    <= 1'b0;
            sb_access_q <= 1'b0;
        end else begin
            sb_ack_q    <= link.sb_req && !sb_ack_q;
            sb_access_q <= link.sb_req && !sb_ack_q;
        end
    end

    // Answers and status on the link.
    assign link.pkt_ack    = ack_q;
    assign link.sb_ack     = sb_ack_q;
    assign link.bus_locked = bus_locked_q;
    assign link.dn_locked  = dn_locked_q;
    assign link.lock_port  = lock_port_q;

endmodule
